/* File: rtl/global_io_control_defs.svh */
// Purpose: offsets, field positions, reset values and timing counts of the
//          global i/o control register bank
// Assumes: byte addressed register port, 32-bit registers stored MSB first
// Notes:   definitions only
`ifndef GLOBAL_IO_CONTROL_DEFS_SVH
`define GLOBAL_IO_CONTROL_DEFS_SVH

// byte addresses
`define ADDR_PORT_INT_STATUS 16'h0018
`define ADDR_PORT_INT_MASK   16'h001C
`define ADDR_SERIAL_IO       16'h0100
`define ADDR_OUT_CLOCK       16'h0103
`define ADDR_INBAND_MGMT_CONTROL     16'h0104

// port interrupt layout: ports 1..4 at bits 3:0, port 5 at bit 6
`define PORT_BITS_MASK       32'h0000_004F
`define PORT_COUNT           5

// serial i/o control
`define SIO_RESET            8'h42
`define SIO_PREAMBLE_BIT     2
`define SIO_AUTO_EDGE_BIT    1
`define SIO_MANUAL_EDGE_BIT  0

// output clock control
`define OCC_RESET            8'h02
`define OCC_WRITE_MASK       8'h1F
`define OCC_READY_BIT        7
`define OCC_SOURCE_HI        4
`define OCC_SOURCE_LO        2
`define OCC_ENABLE_BIT       1
`define OCC_FREQ_BIT         0
`define OCC_SOURCE_XTAL      3'h0
`define OCC_SOURCE_LAST      3'h5

// in-band management control
`define IBA_RESET            32'h0046_40FE
`define IBA_WRITE_MASK       32'hE0C7_FFFF
`define IBA_ENABLE_BIT       31
`define IBA_DA_CHECK_BIT     30
`define IBA_SM_RESET_BIT     29
`define IBA_QUEUE_HI         23
`define IBA_QUEUE_LO         22
`define IBA_PORT_HI          18
`define IBA_PORT_LO          16

// timing: serial clocks with rising edges two ref_clk cycles apart (10 MHz) count as fast; sampling resolves at
// most one edge every second ref_clk cycle, so two cycles is the floor
`define REF_CLK_PERIOD_NS    50
`define SPI_FAST_PERIOD_NS   40
`define SPI_FAST_CYCLES \
  (((`SPI_FAST_PERIOD_NS / `REF_CLK_PERIOD_NS) < 2) ? 2 : \
   (`SPI_FAST_PERIOD_NS / `REF_CLK_PERIOD_NS))
`define STRAP_SETTLE_CYCLES  2'h2

`endif

/* File: rtl/global_io_control_pkg.sv */
// Purpose: shared types of the global i/o control register bank
// Assumes: nothing
// Notes:   numeric constants live in global_io_control_defs.svh
package global_io_control_pkg;
  typedef logic [7:0]  byte_type;
  typedef logic [15:0] addr_type;
  typedef logic [31:0] word_type;
  typedef logic [6:0]  port_bits_type;
  typedef logic [4:0]  clock_ready_type;
endpackage

/* File: rtl/global_io_control_regs.sv */
// Purpose: global port interrupt mask, serial i/o, output clock and in-band
//          management control registers of a five port switch
// Assumes: one clock ref_clk at 20 MHz; register accesses arrive one byte at
//          a time from the serial management front end on the same clock
// Notes:   multi-byte registers are stored MSB at the lowest address
//
// Overview of operation
// - mask bit one blocks that port's interrupt; all masks reset to zero
// - ports one to four at bits 3:0, port five at bit 6; rest read-only
// - port interrupt status has one read-only pending bit per port, same layout
// - preamble suppression bit 2: zero requires preamble, one accepts without
// - preamble suppression affects only the mdio interface, not spi or i2c
// - auto edge: rising edge out for fast serial clock, falling for slow
// - auto edge select bit 1 resets on; manual bit ignored while on
// - with auto off, bit 0 picks edge: zero falling, one rising; resets zero
// - read-only bit 7 shows whether the selected recovered clock is ready
// - source field 4:2: 000 crystal, 001-101 port recovered clocks, else reserved
// - bit 1 enables the sync clock output pin; resets to one
// - bit 0 picks sync clock frequency: zero 25 MHz, one 125 MHz; resets zero
// - bit 31 enables in-band management; reset value taken from a strap pin
// - bit 30 enables destination address check of in-band frames
// - writing one to bit 29 resets the in-band state machine, self clearing
// - bits 23:22 pick the response priority queue, reset 01
// - bits 18:16 pick the in-band port, 000-011 ports 1-4, 110 port 5
// - bits 15:0 hold the in-band frame type value, reset 40FE
`include "global_io_control_defs.svh"

module global_io_control_regs (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  // register access port
  input  wire global_io_control_pkg::addr_type     reg_addr,
  input  wire global_io_control_pkg::byte_type     reg_wdata,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  output      global_io_control_pkg::byte_type     reg_rdata,
  // port interrupt sources and request output
  input  wire global_io_control_pkg::port_bits_type port_int_pending,
  output      logic                                int_request_n,
  // pins from outside the clock domain
  input  wire logic                                serial_clock_pin,
  input  wire global_io_control_pkg::clock_ready_type recovered_clock_ready,
  input  wire logic                                receive_control_strap_pin,
  // serial management controls
  output      logic                                miim_preamble_suppress,
  output      logic                                spi_out_rising_edge,
  // sync clock output controls
  output      logic [2:0]                          sync_clock_out_source,
  output      logic                                sync_clock_out_enable,
  output      logic                                sync_clock_out_fast,
  // in-band management controls
  output      logic                                in_band_management_enable,
  output      logic                                in_band_da_check,
  output      logic                                in_band_sm_reset,
  output      logic [1:0]                          in_band_resp_queue,
  output      logic [2:0]                          in_band_port,
  output      logic [15:0]                         in_band_frame_type
);
  import global_io_control_pkg::*;

  word_type        port_mask;
  byte_type        serial_io;
  byte_type        out_clock;
  word_type        inband_mgmt_control;
  logic            rec_ready;
  clock_ready_type ready_meta;
  clock_ready_type ready_sync;
  logic [1:0]      sclk_meta;
  logic            sclk_sync;
  logic            sclk_prev;
  logic [3:0]      sclk_count;
  logic            sclk_fast;
  logic            strap_meta;
  logic            strap_sync;
  logic [1:0]      strap_wait;
  logic            strap_done;
  word_type        lane;
  word_type        wide_wdata;
  word_type        next_iba;
  word_type        next_mask;
  byte_type        next_rdata;
  logic            write_mask;
  logic            write_sio;
  logic            write_occ;
  logic            write_iba;

  // byte lane of a word register, most significant byte at the base address
  assign lane       = 32'hFF00_0000 >> {reg_addr[1:0], 3'b000};
  assign wide_wdata = {4{reg_wdata}};
  assign write_mask = reg_write && (reg_addr[15:2] == `ADDR_PORT_INT_MASK >> 2);
  assign write_sio  = reg_write && (reg_addr == `ADDR_SERIAL_IO);
  assign write_occ  = reg_write && (reg_addr == `ADDR_OUT_CLOCK);
  assign write_iba  = reg_write && (reg_addr[15:2] == `ADDR_INBAND_MGMT_CONTROL >> 2);

  // reserved mask bits never store, so they always read zero
  assign next_mask = (port_mask & ~lane) | (wide_wdata & lane & `PORT_BITS_MASK);
  assign next_iba  = (inband_mgmt_control & ~(lane & `IBA_WRITE_MASK))
                   | (wide_wdata & lane & `IBA_WRITE_MASK);

  // two-flop synchronisers for every pin
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_meta <= 5'h00;
      ready_sync <= 5'h00;
      sclk_meta  <= 2'h0;
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      ready_meta <= recovered_clock_ready;
      ready_sync <= ready_meta;
      sclk_meta  <= {sclk_meta[0], serial_clock_pin};
      strap_meta <= receive_control_strap_pin;
      strap_sync <= strap_meta;
    end
  end
  assign sclk_sync = sclk_meta[1];

  // serial clock rate: cycles between sampled rising edges; an edge every second
  // cycle is the fastest rate sampling resolves and reads as fast; faster clocks
  // alias, so a host running them should use manual edge selection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev  <= 1'b0;
      sclk_count <= 4'h0;
      sclk_fast  <= 1'b0;
    end else begin
      sclk_prev <= sclk_sync;
      if (sclk_sync && !sclk_prev) begin
        sclk_count <= 4'h0;
        sclk_fast  <= ({28'h000_0000, sclk_count} + 32'h0000_0001) <= `SPI_FAST_CYCLES;
      end else if (sclk_count != 4'hF) begin
        sclk_count <= sclk_count + 4'h1;
      end
    end
  end

  // strap capture waits for the synchroniser to fill after reset release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      strap_done <= (strap_wait == `STRAP_SETTLE_CYCLES);
    end
  end

  // port interrupt mask
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_mask <= 32'h0000_0000;
    end else if (write_mask) begin
      port_mask <= next_mask;
    end
  end

  // serial i/o control; reserved high bits are plain storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_io <= `SIO_RESET;
    end else if (write_sio) begin
      serial_io <= reg_wdata;
    end
  end

  // output clock control, ready bit is not stored here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_clock <= `OCC_RESET;
    end else if (write_occ) begin
      out_clock <= reg_wdata & `OCC_WRITE_MASK;
    end
  end

  // in-band control; a write in the strap cycle wins over the strap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      inband_mgmt_control <= `IBA_RESET;
    end else begin
      if (write_iba) begin
        inband_mgmt_control <= next_iba;
      end else if (strap_wait == `STRAP_SETTLE_CYCLES && !strap_done) begin
        inband_mgmt_control[`IBA_ENABLE_BIT] <= strap_sync;
      end
      inband_mgmt_control[`IBA_SM_RESET_BIT] <= 1'b0;
    end
  end

  // one-cycle state machine reset when software writes a one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_band_sm_reset <= 1'b0;
    end else begin
      in_band_sm_reset <= write_iba && lane[`IBA_SM_RESET_BIT]
                          && reg_wdata[`IBA_SM_RESET_BIT - 24];
    end
  end

  // ready of the selected clock; the crystal input counts as always ready
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_ready <= 1'b0;
    end else if (out_clock[`OCC_SOURCE_HI:`OCC_SOURCE_LO] == `OCC_SOURCE_XTAL) begin
      rec_ready <= 1'b1;
    end else if (out_clock[`OCC_SOURCE_HI:`OCC_SOURCE_LO] <= `OCC_SOURCE_LAST) begin
      rec_ready <= ready_sync[out_clock[`OCC_SOURCE_HI:`OCC_SOURCE_LO] - 3'h1];
    end else begin
      rec_ready <= 1'b0;
    end
  end

  // interrupt request, active low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_request_n <= 1'b1;
    end else begin
      int_request_n <= ~|(port_int_pending & ~port_mask[6:0]);
    end
  end

  // control outputs registered from the bank
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      miim_preamble_suppress    <= 1'b0;
      spi_out_rising_edge       <= 1'b0;
      sync_clock_out_source     <= 3'h0;
      sync_clock_out_enable     <= 1'b1;
      sync_clock_out_fast       <= 1'b0;
      in_band_management_enable <= 1'b0;
      in_band_da_check          <= 1'b0;
      in_band_resp_queue        <= 2'h1;
      in_band_port              <= 3'h6;
      in_band_frame_type        <= 16'h40FE;
    end else begin
      // only the mdio slave reads this; spi and i2c never see it
      miim_preamble_suppress    <= serial_io[`SIO_PREAMBLE_BIT];
      spi_out_rising_edge       <= serial_io[`SIO_AUTO_EDGE_BIT] ? sclk_fast
                                 : serial_io[`SIO_MANUAL_EDGE_BIT];
      sync_clock_out_source     <= out_clock[`OCC_SOURCE_HI:`OCC_SOURCE_LO];
      sync_clock_out_enable     <= out_clock[`OCC_ENABLE_BIT];
      sync_clock_out_fast       <= out_clock[`OCC_FREQ_BIT];
      in_band_management_enable <= inband_mgmt_control[`IBA_ENABLE_BIT];
      in_band_da_check          <= inband_mgmt_control[`IBA_DA_CHECK_BIT];
      in_band_resp_queue        <= inband_mgmt_control[`IBA_QUEUE_HI:`IBA_QUEUE_LO];
      in_band_port              <= inband_mgmt_control[`IBA_PORT_HI:`IBA_PORT_LO];
      in_band_frame_type        <= inband_mgmt_control[15:0];
    end
  end

  // read mux; unmapped bytes read zero
  always_comb begin
    if (reg_addr[15:2] == `ADDR_PORT_INT_STATUS >> 2) begin
      next_rdata = 8'((({25'h000_0000, port_int_pending} & `PORT_BITS_MASK) & lane)
                      >> {~reg_addr[1:0], 3'b000});
    end else if (reg_addr[15:2] == `ADDR_PORT_INT_MASK >> 2) begin
      next_rdata = 8'((port_mask & lane) >> {~reg_addr[1:0], 3'b000});
    end else if (reg_addr == `ADDR_SERIAL_IO) begin
      next_rdata = serial_io;
    end else if (reg_addr == `ADDR_OUT_CLOCK) begin
      next_rdata = {rec_ready, out_clock[6:0]};
    end else if (reg_addr[15:2] == `ADDR_INBAND_MGMT_CONTROL >> 2) begin
      next_rdata = 8'((inband_mgmt_control & lane) >> {~reg_addr[1:0], 3'b000});
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_int_masked;
    ((port_int_pending & ~port_mask[6:0]) == 7'h00) |=> int_request_n;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("masked request seen");

  property p_int_active;
    ((port_int_pending & ~port_mask[6:0]) != 7'h00) |=> !int_request_n;
  endproperty
  a_int_active: assert property (p_int_active) else $error("unmasked interrupt not seen");

  property p_mask_reserved;
    (port_mask & ~`PORT_BITS_MASK) == 32'h0000_0000;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("reserved mask bit set");

  property p_sm_reset_pulse;
    in_band_sm_reset && !(write_iba && lane[`IBA_SM_RESET_BIT]
                          && reg_wdata[`IBA_SM_RESET_BIT - 24])
      |=> !in_band_sm_reset && !inband_mgmt_control[`IBA_SM_RESET_BIT];
  endproperty
  a_sm_reset_pulse: assert property (p_sm_reset_pulse) else $error("sm reset too long");

  property p_manual_edge;
    !serial_io[`SIO_AUTO_EDGE_BIT] ##1 !serial_io[`SIO_AUTO_EDGE_BIT]
      |-> spi_out_rising_edge == $past(serial_io[`SIO_MANUAL_EDGE_BIT]);
  endproperty
  a_manual_edge: assert property (p_manual_edge) else $error("manual edge not followed");

  property p_auto_edge;
    serial_io[`SIO_AUTO_EDGE_BIT] |=> spi_out_rising_edge == $past(sclk_fast);
  endproperty
  a_auto_edge: assert property (p_auto_edge) else $error("auto edge not followed");

  property p_preamble;
    write_sio |=> ##1 miim_preamble_suppress == $past(reg_wdata[`SIO_PREAMBLE_BIT], 2);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble setting lost");

  property p_ready_xtal;
    out_clock[`OCC_SOURCE_HI:`OCC_SOURCE_LO] == `OCC_SOURCE_XTAL |=> rec_ready;
  endproperty
  a_ready_xtal: assert property (p_ready_xtal) else $error("crystal source not ready");

  property p_frame_type;
    write_iba && reg_addr[1:0] == 2'h3 |=> ##1 in_band_frame_type[7:0] == $past(reg_wdata, 2);
  endproperty
  a_frame_type: assert property (p_frame_type) else $error("frame type not written");

  c_sm_reset: cover property (in_band_sm_reset);
  c_int_fire: cover property (int_request_n ##1 !int_request_n);
  c_fast_clock: cover property (!spi_out_rising_edge ##1 spi_out_rising_edge);
endmodule

/* File: tb/serial_host_model.sv */
// Purpose: far side model that drives the spi serial clock pin
// Assumes: the bench asks for a frame through frame_on
// Notes:   400 ns period inside frames, pin idles low between frames
module serial_host_model (
  // frame request from the bench
  input  wire logic frame_on,
  // serial clock towards the device pin
  output      logic serial_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // free running phase, offset so it never lines up with ref_clk;
  // gating it keeps the pin still outside frames as a real host would
  logic phase = 1'b0;
  initial #7 forever #200 phase = ~phase;
  assign serial_clock = frame_on & phase;
endmodule

/* File: tb/global_io_control_regs_bench.sv */
// Purpose: self-checking bench of the global i/o control register bank
// Assumes: byte strobe register port, inputs driven on falling ref_clk
// Notes:   serial clock comes from serial_host_model, strap held high until the strap-low reset
`include "global_io_control_defs.svh"

module global_io_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import global_io_control_pkg::*;

  logic            ref_clk = 1'b0;
  logic            reset_n = 1'b0;
  addr_type        reg_addr = '0;
  byte_type        reg_wdata = '0;
  logic            reg_write = 1'b0;
  logic            reg_read = 1'b0;
  byte_type        reg_rdata;
  port_bits_type   port_int_pending = '0;
  logic            int_request_n;
  logic            frame_on = 1'b0;
  logic            serial_clock_pin;
  clock_ready_type recovered_clock_ready = '0;
  logic            strap = 1'b1;
  logic            miim, rise, sc_en, sc_fast, ib_en, ib_da, ib_rst;
  logic [2:0]      sc_src, ib_port;
  logic [1:0]      ib_q;
  logic [15:0]     ib_type;
  int              fails = 0;
  int              checks_done = 0;

  // 20 MHz reference clock
  always #25 ref_clk = ~ref_clk;

  serial_host_model i_host (.frame_on(frame_on), .serial_clock(serial_clock_pin));

  global_io_control_regs i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_int_pending(port_int_pending), .int_request_n(int_request_n),
    .serial_clock_pin(serial_clock_pin), .recovered_clock_ready(recovered_clock_ready),
    .receive_control_strap_pin(strap), .miim_preamble_suppress(miim),
    .spi_out_rising_edge(rise), .sync_clock_out_source(sc_src),
    .sync_clock_out_enable(sc_en), .sync_clock_out_fast(sc_fast),
    .in_band_management_enable(ib_en), .in_band_da_check(ib_da),
    .in_band_sm_reset(ib_rst), .in_band_resp_queue(ib_q), .in_band_port(ib_port),
    .in_band_frame_type(ib_type));

  task automatic print_verdict;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // single bit comparison
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // field comparison, narrower fields zero extended by the caller
  task automatic cmp_word(input word_type got, input word_type exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one byte write, strobe held for exactly one rising edge
  task automatic wr(input addr_type a, input byte_type d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask

  // one byte read, data taken once the read edge has landed
  task automatic rd_cmp(input addr_type a, input byte_type exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    cmp_word({24'h00_0000, reg_rdata}, {24'h00_0000, exp}, "read byte");
  endtask

  // reset values; the in-band enable follows the strap level held at release
  task automatic check_reset_values(input logic strap_level);
    rd_cmp(`ADDR_SERIAL_IO, 8'h42);
    rd_cmp(`ADDR_OUT_CLOCK, 8'h82);
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL, {strap_level, 7'h00});
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL + 16'h0001, 8'h46);
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL + 16'h0002, 8'h40);
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL + 16'h0003, 8'hFE);
    for (int i = 0; i < 4; i++) begin
      rd_cmp(`ADDR_PORT_INT_MASK + 16'(i), 8'h00);
    end
    cmp_bit(ib_en, strap_level, "strap enable");
    cmp_word(32'(ib_port), 32'h6, "port reset");
    cmp_word(32'(ib_q), 32'h1, "queue reset");
    cmp_word(32'(ib_type), 32'h40FE, "type reset");
    cmp_bit(sc_en, 1'b1, "clock out reset");
    cmp_bit(sc_fast, 1'b0, "25 MHz reset");
    cmp_word(32'(sc_src), 32'h0, "source reset");
    cmp_bit(miim, 1'b0, "preamble reset");
    cmp_bit(rise, 1'b0, "edge reset");
    cmp_bit(ib_da, 1'b0, "check reset");
    cmp_bit(int_request_n, 1'b1, "no request");
  endtask

  // every port raised, then each opened alone through the mask
  task automatic interrupt_masking;
    port_int_pending = 7'h4F;
    idle(2);
    cmp_bit(int_request_n, 1'b0, "unmasked request");
    rd_cmp(`ADDR_PORT_INT_STATUS + 16'h0003, 8'h4F);
    wr(`ADDR_PORT_INT_MASK + 16'h0003, 8'hFF);
    rd_cmp(`ADDR_PORT_INT_MASK + 16'h0003, 8'h4F);
    cmp_bit(int_request_n, 1'b1, "all masked");
    wr(`ADDR_PORT_INT_MASK + 16'h0002, 8'hFF);
    rd_cmp(`ADDR_PORT_INT_MASK + 16'h0002, 8'h00);
    // clearing a port bit opens it; clearing a reserved bit opens nothing
    for (int i = 0; i < 7; i++) begin
      wr(`ADDR_PORT_INT_MASK + 16'h0003, 8'h4F & ~(8'h01 << i));
      idle(2);
      cmp_bit(int_request_n, ((8'h4F >> i) & 8'h01) == 8'h00, "one open");
    end
    port_int_pending = 7'h00;
    idle(2);
    cmp_bit(int_request_n, 1'b1, "nothing pending");
  endtask

  // slow serial clock inside a frame, auto and manual edge choice
  task automatic serial_edge_select;
    frame_on = 1'b1;
    wr(`ADDR_SERIAL_IO, 8'h47);
    idle(30);
    cmp_bit(miim, 1'b1, "preamble suppress");
    cmp_bit(rise, 1'b0, "auto edge slow");
    wr(`ADDR_SERIAL_IO, 8'h41);
    idle(2);
    cmp_bit(rise, 1'b1, "manual rising");
    wr(`ADDR_SERIAL_IO, 8'h40);
    idle(2);
    cmp_bit(rise, 1'b0, "manual falling");
    cmp_bit(miim, 1'b0, "preamble needed");
    rd_cmp(`ADDR_SERIAL_IO, 8'h40);
    frame_on = 1'b0;
  endtask

  // every source code, with ports one, three and five ready
  task automatic clock_source_select;
    logic rdy;
    recovered_clock_ready = 5'h15;
    for (int s = 0; s < 8; s++) begin
      wr(`ADDR_OUT_CLOCK, {3'h0, 3'(s), 2'h1});
      idle(4);
      rdy = (s == 0) ? 1'b1 : (s < 6) ? recovered_clock_ready[s - 1] : 1'b0;
      rd_cmp(`ADDR_OUT_CLOCK, {rdy, 2'h0, 3'(s), 2'h1});
      cmp_word(32'(sc_src), 32'(s), "source out");
    end
    cmp_bit(sc_en, 1'b0, "clock out off");
    cmp_bit(sc_fast, 1'b1, "125 MHz");
  endtask

  task automatic inband_control;
    int n;
    wr(`ADDR_INBAND_MGMT_CONTROL, 8'h40);
    idle(2);
    cmp_bit(ib_en, 1'b0, "in-band off");
    cmp_bit(ib_da, 1'b1, "address check");
    wr(`ADDR_INBAND_MGMT_CONTROL + 16'h0001, 8'hFF);
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL + 16'h0001, 8'hC7);
    wr(`ADDR_INBAND_MGMT_CONTROL + 16'h0001, 8'h85);
    wr(`ADDR_INBAND_MGMT_CONTROL + 16'h0002, 8'h12);
    wr(`ADDR_INBAND_MGMT_CONTROL + 16'h0003, 8'h34);
    idle(2);
    cmp_word(32'(ib_q), 32'h2, "queue");
    cmp_word(32'(ib_port), 32'h5, "port");
    cmp_word(32'(ib_type), 32'h1234, "frame type");
    wr(`ADDR_INBAND_MGMT_CONTROL, 8'hA0);
    n = 0;
    repeat (4) begin
      n += int'(ib_rst === 1'b1);
      @(negedge ref_clk);
    end
    cmp_word(32'(n), 32'h1, "reset pulse");
    rd_cmp(`ADDR_INBAND_MGMT_CONTROL, 8'h80);
    cmp_bit(ib_en, 1'b1, "in-band on");
    cmp_bit(ib_da, 1'b0, "address check off");
  endtask

  // mid-run reset with the strap low: the enable must follow the strap, not
  // the value software left behind, and every other field must return
  task automatic reset_strap_low;
    strap = 1'b0;
    reset_n = 1'b0;
    idle(2);
    cmp_bit(ib_en, 1'b0, "enable in reset");
    reset_n = 1'b1;
    idle(6);
    check_reset_values(1'b0);
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    idle(6);
    check_reset_values(1'b1);
    interrupt_masking();
    serial_edge_select();
    clock_source_select();
    inband_control();
    reset_strap_low();
    print_verdict();
  end
endmodule
